// file: verilog/dhbi_top.sv
`timescale 1ns/1ps
`include "dhbi_defs.svh"
module dhbi_top #(
	parameter int BIT_CYCLES = `DHBI_BIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// configuration straps
	input wire logic [1:0] mode_strap,
	input wire logic usb_variant,
	// host connector: rx / clock line
	input wire logic rx_pin,
	// host connector: tx / data line
	input wire logic tx_in,
	output logic tx_out,
	output logic tx_oe_n,
	// virtual serial byte port
	input wire logic usb_valid,
	input wire logic [7:0] usb_data,
	// decoded stream
	output dhbi_pkg::dhbi_evt_t char_evt,
	output dhbi_pkg::dhbi_evt_t ctrl_evt,
	output dhbi_pkg::dhbi_evt_t cmd_evt,
	output dhbi_pkg::dhbi_evt_t param_evt,
	output logic clear_screen,
	// status
	output dhbi_pkg::dhbi_mode_t mode,
	output logic mode_ready,
	output logic [7:0] i2c_addr
);

	if (BIT_CYCLES < 4 || BIT_CYCLES >= (1 << `DHBI_CNT_W)) begin : g_chk
		$error("BIT_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode strap capture, once after release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= dhbi_pkg::DHBI_MODE_RS232;
			mode_ready <= 1'b0;
		end else if (!mode_ready) begin
			mode_ready <= 1'b1;
			if (usb_variant)
				mode <= dhbi_pkg::DHBI_MODE_USB;
			else if (mode_strap == `DHBI_STRAP_I2C)
				mode <= dhbi_pkg::DHBI_MODE_I2C;
			else if (mode_strap == `DHBI_STRAP_TTL)
				mode <= dhbi_pkg::DHBI_MODE_TTL;
			else
				mode <= dhbi_pkg::DHBI_MODE_RS232;
		end
	end

	logic is_serial;
	logic is_i2c;
	assign is_serial = mode_ready && (mode == dhbi_pkg::DHBI_MODE_RS232 ||
		mode == dhbi_pkg::DHBI_MODE_TTL);
	assign is_i2c = mode_ready && mode == dhbi_pkg::DHBI_MODE_I2C;

	////////////////////////////////////////////////////////////////////
	// serial receiver, 8N1, no flow control
	localparam int HALF = BIT_CYCLES / 2;
	dhbi_pkg::dhbi_uart_t ust;
	logic [`DHBI_CNT_W-1:0] ucnt;
	logic [2:0] ubit;
	logic [7:0] ushift;
	logic u_valid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ust <= dhbi_pkg::DHBI_U_IDLE;
			ucnt <= '0;
			ubit <= 3'h0;
			ushift <= 8'h00;
			u_valid <= 1'b0;
		end else begin
			u_valid <= 1'b0;
			if (ucnt != '0)
				ucnt <= ucnt - 1'b1;
			case (ust)
			dhbi_pkg::DHBI_U_IDLE: begin
				if (is_serial && !rx_pin) begin
					ust <= dhbi_pkg::DHBI_U_START;
					ucnt <= `DHBI_CNT_W'(HALF);
				end
			end
			dhbi_pkg::DHBI_U_START: begin
				if (ucnt == '0) begin
					// glitch shorter than half a bit is dropped
					if (rx_pin) begin
						ust <= dhbi_pkg::DHBI_U_IDLE;
					end else begin
						ust <= dhbi_pkg::DHBI_U_DATA;
						ubit <= 3'h0;
						// one short: the zero cycle belongs to the bit
						ucnt <= `DHBI_CNT_W'(BIT_CYCLES - 1);
					end
				end
			end
			dhbi_pkg::DHBI_U_DATA: begin
				if (ucnt == '0) begin
					ushift <= {rx_pin, ushift[7:1]};
					ubit <= ubit + 3'h1;
					ucnt <= `DHBI_CNT_W'(BIT_CYCLES - 1);
					if (ubit == 3'(`DHBI_DATA_BITS - 1))
						ust <= dhbi_pkg::DHBI_U_STOP;
				end
			end
			default: begin
				if (ucnt == '0) begin
					// framing error: byte silently dropped
					u_valid <= rx_pin;
					ust <= dhbi_pkg::DHBI_U_IDLE;
				end
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// two-wire target, write only; reads are not acknowledged
	logic scl_q;
	logic sda_q;
	dhbi_pkg::dhbi_i2c_t ist;
	logic [3:0] ibits;
	logic [7:0] ishift;
	logic i_ack;
	logic i_valid;
	logic scl_rise;
	logic scl_fall;
	logic i_start;
	logic i_stop;

	assign scl_rise = rx_pin && !scl_q;
	assign scl_fall = !rx_pin && scl_q;
	assign i_start = rx_pin && scl_q && sda_q && !tx_in;
	assign i_stop = rx_pin && scl_q && !sda_q && tx_in;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			ist <= dhbi_pkg::DHBI_I_IDLE;
			ibits <= 4'h0;
			ishift <= 8'h00;
			i_ack <= 1'b0;
			i_valid <= 1'b0;
		end else begin
			scl_q <= rx_pin;
			sda_q <= tx_in;
			i_valid <= 1'b0;
			if (!is_i2c || i_stop) begin
				ist <= dhbi_pkg::DHBI_I_IDLE;
				i_ack <= 1'b0;
			end else if (i_start) begin
				ist <= dhbi_pkg::DHBI_I_ADDR;
				ibits <= 4'h0;
				i_ack <= 1'b0;
			end else begin
				case (ist)
				dhbi_pkg::DHBI_I_ADDR, dhbi_pkg::DHBI_I_DATA: begin
					if (scl_rise && ibits != 4'h8) begin
						ishift <= {ishift[6:0], tx_in};
						ibits <= ibits + 4'h1;
					end else if (scl_fall && ibits == 4'h8) begin
						if (ist == dhbi_pkg::DHBI_I_DATA) begin
							i_ack <= 1'b1;
							i_valid <= 1'b1;
							ist <= dhbi_pkg::DHBI_I_DACK;
						end else if (ishift[7:1] == i2c_addr[7:1] &&
							!ishift[0]) begin
							i_ack <= 1'b1;
							ist <= dhbi_pkg::DHBI_I_AACK;
						end else begin
							ist <= dhbi_pkg::DHBI_I_IDLE;
						end
					end
				end
				dhbi_pkg::DHBI_I_AACK, dhbi_pkg::DHBI_I_DACK: begin
					if (scl_fall) begin
						i_ack <= 1'b0;
						ibits <= 4'h0;
						ist <= dhbi_pkg::DHBI_I_DATA;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// tx idles at mark in serial modes; open drain on the data line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_out <= 1'b1;
			tx_oe_n <= 1'b1;
		end else begin
			tx_out <= !is_i2c;
			tx_oe_n <= is_i2c ? !i_ack : !is_serial;
		end
	end

	////////////////////////////////////////////////////////////////////
	// byte source select
	logic b_valid;
	logic [7:0] b_data;

	always_comb begin
		b_valid = 1'b0;
		b_data = ushift;
		if (is_serial) begin
			b_valid = u_valid;
		end else if (is_i2c) begin
			b_valid = i_valid;
		end else if (mode_ready && mode == dhbi_pkg::DHBI_MODE_USB) begin
			b_valid = usb_valid;
			b_data = usb_data;
		end
		if (is_i2c)
			b_data = ishift;
	end

	////////////////////////////////////////////////////////////////////
	// command interpreter
	function automatic logic [7:0] param_count(input logic [7:0] code);
		// unknown commands take no parameters
		if (code == `DHBI_CMD_SET_ADDR)
			param_count = 8'h01;
		else
			param_count = 8'h00;
	endfunction : param_count

	dhbi_pkg::dhbi_ist_t cst;
	logic [7:0] cur_cmd;
	logic [7:0] pleft;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cst <= dhbi_pkg::DHBI_TEXT;
			cur_cmd <= 8'h00;
			pleft <= 8'h00;
			char_evt <= '0;
			ctrl_evt <= '0;
			cmd_evt <= '0;
			param_evt <= '0;
			clear_screen <= 1'b0;
		end else begin
			char_evt.valid <= 1'b0;
			ctrl_evt.valid <= 1'b0;
			cmd_evt.valid <= 1'b0;
			param_evt.valid <= 1'b0;
			clear_screen <= 1'b0;
			if (b_valid) begin
				case (cst)
				dhbi_pkg::DHBI_TEXT: begin
					if (b_data == `DHBI_CMD_PREFIX) begin
						cst <= dhbi_pkg::DHBI_CMD;
					end else if (b_data < `DHBI_CTRL_LIMIT) begin
						ctrl_evt <= '{1'b1, b_data};
					end else begin
						char_evt <= '{1'b1, b_data};
					end
				end
				dhbi_pkg::DHBI_CMD: begin
					cmd_evt <= '{1'b1, b_data};
					cur_cmd <= b_data;
					pleft <= param_count(b_data);
					clear_screen <= b_data == `DHBI_CMD_CLEAR;
					if (param_count(b_data) == 8'h00)
						cst <= dhbi_pkg::DHBI_TEXT;
					else
						cst <= dhbi_pkg::DHBI_PARAM;
				end
				default: begin
					param_evt <= '{1'b1, b_data};
					pleft <= pleft - 8'h01;
					if (pleft == 8'h01)
						cst <= dhbi_pkg::DHBI_TEXT;
				end
				endcase
			end
		end
	end

	// target address register, changed only by command
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			i2c_addr <= `DHBI_I2C_ADDR_DEF;
		else if (b_valid && cst == dhbi_pkg::DHBI_PARAM &&
			cur_cmd == `DHBI_CMD_SET_ADDR)
			i2c_addr <= {b_data[7:1], 1'b0};
	end

endmodule : dhbi_top

// file: verilog/dhbi_defs.svh
`ifndef DHBI_DEFS_SVH
`define DHBI_DEFS_SVH

// clock and serial link timing
`define DHBI_CLK_HZ 25000000
`define DHBI_BAUD 19200
`define DHBI_BIT_CYCLES (`DHBI_CLK_HZ / `DHBI_BAUD)
`define DHBI_DATA_BITS 8
`define DHBI_CNT_W 16

// byte values
`define DHBI_CMD_PREFIX 8'hFE
`define DHBI_CMD_CLEAR 8'h58
`define DHBI_CMD_SET_ADDR 8'h33
`define DHBI_CTRL_LIMIT 8'h20

// link target address after reset (8-bit form, write bit clear)
`define DHBI_I2C_ADDR_DEF 8'h50

// mode straps
`define DHBI_STRAP_RS232 2'h0
`define DHBI_STRAP_TTL 2'h1
`define DHBI_STRAP_I2C 2'h2

`endif

// file: verilog/dhbi_pkg.sv
package dhbi_pkg;

	typedef enum logic [1:0] {
		DHBI_MODE_RS232 = 2'h0,
		DHBI_MODE_TTL = 2'h1,
		DHBI_MODE_I2C = 2'h3,
		DHBI_MODE_USB = 2'h2
	} dhbi_mode_t;

	typedef enum logic [1:0] {
		DHBI_TEXT = 2'h0,
		DHBI_CMD = 2'h1,
		DHBI_PARAM = 2'h3
	} dhbi_ist_t;

	typedef enum logic [2:0] {
		DHBI_I_IDLE = 3'h0,
		DHBI_I_ADDR = 3'h1,
		DHBI_I_AACK = 3'h3,
		DHBI_I_DATA = 3'h2,
		DHBI_I_DACK = 3'h6
	} dhbi_i2c_t;

	typedef enum logic [1:0] {
		DHBI_U_IDLE = 2'h0,
		DHBI_U_START = 2'h1,
		DHBI_U_DATA = 2'h3,
		DHBI_U_STOP = 2'h2
	} dhbi_uart_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} dhbi_evt_t;

endpackage : dhbi_pkg

// file: dv/dhbi_asserts.sv
`timescale 1ns/1ps
module dhbi_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// straps and byte port
	input wire logic [1:0] mode_strap,
	input wire logic usb_variant,
	input wire logic usb_valid,
	input wire logic [7:0] usb_data,
	// pins and stream
	input wire logic tx_out,
	input wire logic tx_oe_n,
	input wire dhbi_pkg::dhbi_evt_t char_evt,
	input wire dhbi_pkg::dhbi_evt_t ctrl_evt,
	input wire dhbi_pkg::dhbi_evt_t cmd_evt,
	input wire dhbi_pkg::dhbi_evt_t param_evt,
	input wire logic clear_screen,
	input wire dhbi_pkg::dhbi_mode_t mode,
	input wire logic mode_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [7:0] ud_q;
	logic [3:0] hit;
	logic [3:0] vs;
	always_ff @(posedge clk) begin
		ud_q <= usb_data;
	end
	assign vs = {char_evt.valid, ctrl_evt.valid, cmd_evt.valid,
		param_evt.valid};
	assign hit = vs & {char_evt.data == ud_q, ctrl_evt.data == ud_q,
		cmd_evt.data == ud_q, param_evt.data == ud_q};
	sequence s_usb;
		mode == dhbi_pkg::DHBI_MODE_USB && usb_valid && usb_data != 8'hFE;
	endsequence
	sequence s_clr;
		cmd_evt.valid && cmd_evt.data == 8'h58;
	endsequence
	clr_has_cmd_a: assert property (clear_screen |-> s_clr)
		else $error("clear without its command");
	cmd_clears_a: assert property (s_clr |-> clear_screen)
		else $error("clear command without clear");
	ctrl_range_a: assert property (ctrl_evt.valid |->
		ctrl_evt.data < 8'h20)
		else $error("control event out of range");
	char_range_a: assert property (char_evt.valid |->
		char_evt.data >= 8'h20)
		else $error("glyph event in control range");
	one_event_a: assert property ($onehot0(vs))
		else $error("two events at once");
	// pin drive follows the latched mode one clock later
	serial_idle_a: assert property (mode_ready && mode inside
		{dhbi_pkg::DHBI_MODE_RS232, dhbi_pkg::DHBI_MODE_TTL} |=>
		tx_out && !tx_oe_n)
		else $error("serial tx not driven high");
	link_low_a: assert property (mode_ready &&
		mode == dhbi_pkg::DHBI_MODE_I2C |=> !tx_out)
		else $error("data line drive not low");
	usb_echo_a: assert property (s_usb |=> |hit)
		else $error("virtual port byte lost");
	mode_pick_a: assert property ($rose(mode_ready) |-> mode ==
		(usb_variant ? dhbi_pkg::DHBI_MODE_USB :
		mode_strap == 2'h2 ? dhbi_pkg::DHBI_MODE_I2C :
		mode_strap == 2'h1 ? dhbi_pkg::DHBI_MODE_TTL :
		dhbi_pkg::DHBI_MODE_RS232))
		else $error("wrong link mode");
endmodule : dhbi_asserts
bind dhbi_top dhbi_asserts chk (.clk, .nrst, .mode_strap, .usb_variant,
	.usb_valid, .usb_data, .tx_out, .tx_oe_n, .char_evt, .ctrl_evt, .cmd_evt,
	.param_evt, .clear_screen, .mode, .mode_ready);

// file: dv/dhbi_host.sv
`timescale 1ns/1ps
module dhbi_host #(
	parameter int BC = 8
) (
	// clock and data wire level
	input wire logic clk,
	input wire logic sda_w,
	// rx or clock line; data drive, 1 releases to pull-up
	output logic line,
	output logic sda
);
	initial begin
		line = 1'b1;
		sda = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	task automatic ser(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line = f[i];
			w(BC);
		end
	endtask : ser
	task automatic bt(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda = b[i];
			w(3);
			line = 1'b1;
			w(4);
			line = 1'b0;
			w(1);
		end
		sda = 1'b1;
		w(3);
		line = 1'b1;
		w(2);
		ack = !sda_w;
		w(2);
		line = 1'b0;
		w(2);
	endtask : bt
	// clock line doubles as rx pin; stands high outside frames
	task automatic i2c(input logic [7:0] a, d, output logic ok);
		logic k1;
		logic k2;
		sda = 1'b0;
		w(4);
		line = 1'b0;
		bt(a, k1);
		bt(d, k2);
		sda = 1'b0;
		w(3);
		line = 1'b1;
		w(3);
		sda = 1'b1;
		w(4);
		ok = k1 & k2;
	endtask : i2c
endmodule : dhbi_host

// file: dv/tb_display_host_byte_interface.sv
`timescale 1ns/1ps
module tb_display_host_byte_interface;
	localparam int BC = 8;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] strap = 2'h0;
	logic usbv = 1'b0;
	logic uval = 1'b0;
	logic [7:0] udat = 8'h00;
	logic line, sda, sda_w, tx_out, tx_oe_n, clr, mrdy, ok;
	logic [7:0] addr;
	logic [11:0] last = 12'h000;
	dhbi_pkg::dhbi_evt_t ch, ct, cm, pa;
	dhbi_pkg::dhbi_mode_t md;
	int ev_n = 0;
	int clr_n = 0;
	int mismatches = 0;
	int check_count = 0;
	int k;
	assign sda_w = sda & (tx_oe_n | tx_out);
	dhbi_top #(.BIT_CYCLES(BC)) dut (.clk(clk), .nrst(nrst),
		.mode_strap(strap), .usb_variant(usbv), .rx_pin(line), .tx_in(sda_w),
		.tx_out(tx_out), .tx_oe_n(tx_oe_n), .usb_valid(uval), .usb_data(udat),
		.char_evt(ch), .ctrl_evt(ct), .cmd_evt(cm), .param_evt(pa),
		.clear_screen(clr), .mode(md), .mode_ready(mrdy), .i2c_addr(addr));
	dhbi_host #(.BC(BC)) host (.clk(clk), .sda_w(sda_w), .line(line),
		.sda(sda));
	initial begin
		forever #20 clk = ~clk;
	end
	// kind bits glyph, control, command, parameter above the byte
	always @(posedge clk) begin
		if (ch.valid | ct.valid | cm.valid | pa.valid) begin
			ev_n <= ev_n + 1;
			last <= {ch.valid, ct.valid, cm.valid, pa.valid, ch.valid ? ch.data :
				ct.valid ? ct.data : cm.valid ? cm.data : pa.data};
		end
		if (clr === 1'b1)
			clr_n <= clr_n + 1;
	end
	task results;
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	task check(input string n, input logic [11:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			$display("BAD %s exp %h seen %h", n, exp, seen);
			mismatches++;
		end
	endtask : check
	task wait_ev(input int t);
		for (int i = 0; i < 20 * BC && ev_n < t; i++)
			@(negedge clk);
		if (ev_n < t) begin
			check("event timeout", 12'h0, 12'h1);
			results;
		end
	endtask : wait_ev
	task rst(input logic [1:0] s, input logic u, input dhbi_pkg::dhbi_mode_t m);
		nrst = 1'b0;
		strap = s;
		usbv = u;
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		repeat (6) @(negedge clk);
		check("mode", {10'h0, md}, {10'h0, m});
		check("mode ready", {11'h0, mrdy}, 12'h001);
	endtask : rst
	task sx(input logic [7:0] b, input logic [11:0] e);
		k = ev_n;
		host.ser(b);
		wait_ev(k + 1);
		check("serial byte", last, e);
	endtask : sx
	task ub(input logic [7:0] b);
		uval = 1'b1;
		udat = b;
		@(negedge clk);
		uval = 1'b0;
		@(negedge clk);
	endtask : ub
	task t_serial;
		rst(2'h0, 1'b0, dhbi_pkg::DHBI_MODE_RS232);
		sx(8'h41, 12'h841);
		sx(8'h0D, 12'h40D);
		host.ser(8'hFE);
		sx(8'h58, 12'h258);
		check("clear", 12'(clr_n), 12'h1);
		sx(8'h7E, 12'h87E);
		rst(2'h3, 1'b0, dhbi_pkg::DHBI_MODE_RS232);
		rst(2'h1, 1'b0, dhbi_pkg::DHBI_MODE_TTL);
		sx(8'h20, 12'h820);
	endtask : t_serial
	task t_usb;
		rst(2'h2, 1'b1, dhbi_pkg::DHBI_MODE_USB);
		k = ev_n;
		host.ser(8'h41);
		check("serial in usb", 12'(ev_n - k), 12'h0);
		ub(8'hFE);
		ub(8'h33);
		check("cmd", last, 12'h233);
		ub(8'hFE);
		check("param", last, 12'h1FE);
		check("addr", {4'h0, addr}, 12'h0FE);
		ub(8'h5A);
		check("text again", last, 12'h85A);
	endtask : t_usb
	task t_i2c;
		rst(2'h2, 1'b0, dhbi_pkg::DHBI_MODE_I2C);
		check("addr", {4'h0, addr}, 12'h050);
		k = ev_n;
		host.i2c(8'h52, 8'h41, ok);
		check("nak", {11'h0, ok}, 12'h0);
		check("no byte", 12'(ev_n - k), 12'h0);
		host.i2c(8'h50, 8'h41, ok);
		wait_ev(k + 1);
		check("ack", {11'h0, ok}, 12'h1);
		check("link byte", last, 12'h841);
	endtask : t_i2c
	initial begin
		t_serial;
		t_usb;
		t_i2c;
		results;
	end
endmodule : tb_display_host_byte_interface
